// >>> rtl/ahp_pkg.sv
package ahp_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POR_TIME_US = 250;
  localparam int unsigned WAKE_TIME_MS = 1;
  localparam int unsigned STARTUP_TIME_MS = 2;
  localparam int unsigned MS_CYCLES = 1000000 / CLK_PERIOD_NS;
  // longest time, so rounded down
  localparam int unsigned POR_CYCLES = POR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_MS * MS_CYCLES;
  localparam int unsigned STARTUP_CYCLES = STARTUP_TIME_MS * MS_CYCLES;
  localparam logic [6:0] DRDY_PULSE_CYCLES = 7'h40;

  // ***************************************************************
  // addressing and register map
  // ***************************************************************
  localparam logic [5:0] ADDR_PREFIX = 6'h09;
  localparam logic [7:0] REG_CHIP_ID = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h0A;
  localparam logic [7:0] REG_ODR = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h11;
  localparam logic [7:0] REG_INTERRUPT_OUT_ONE_MAP = 8'h19;
  localparam logic [7:0] REG_INTERRUPT_OUT_TWO_MAP = 8'h1B;
  localparam logic [7:0] REG_IFCFG = 8'h20;
  localparam logic [7:0] REG_RESET = 8'h36;
  localparam logic [7:0] SOFT_RESET_CODE = 8'hB6;
  localparam int unsigned MODE_BIT = 7;
  localparam int unsigned SPI_RW_BIT = 7;
  localparam int unsigned SPI3W_BIT = 0;
  localparam int unsigned STAT_DRDY_BIT = 0;
  localparam int unsigned STAT_MOTION_BIT = 1;
  localparam logic [3:0] ODR_DEFAULT = 4'h4;
  localparam logic [1:0] MAP_DEFAULT = 2'h0;

  typedef enum logic [1:0] {MODE_POR, MODE_STANDBY, MODE_WAKE, MODE_ACTIVE}
    ahp_mode_t;
  typedef enum logic [2:0] {SER_IDLE, SER_DEVADDR, SER_ACK, SER_PTR,
    SER_WRITE, SER_READ, SER_RDACK} ahp_ser_t;

  // sample period in millisecond ticks: 1000 down to 1.25 samples/s
  function automatic logic [9:0] odr_ticks(input logic [3:0] code);
    unique case (code)
      4'h0: odr_ticks = 10'h001;
      4'h1: odr_ticks = 10'h002;
      4'h2: odr_ticks = 10'h004;
      4'h3: odr_ticks = 10'h008;
      4'h4: odr_ticks = 10'h00A;
      4'h5: odr_ticks = 10'h014;
      4'h6: odr_ticks = 10'h028;
      4'h7: odr_ticks = 10'h050;
      4'h8: odr_ticks = 10'h0A0;
      default: odr_ticks = 10'h320;
    endcase
  endfunction

endpackage

// >>> rtl/ahp_host_port.sv
`timescale 1ns/10ps
// Summary of operation
// R1: power-on reset loads every register default and the device then waits in standby.
// R2: the device is a two-wire bus slave answering one 7-bit address.
// R3: address bits 6..1 are fixed 001001 and bit 0 follows the strap pin.
// R4: the bus runs at 100 kHz or 400 kHz and the master never exceeds 400 kHz; the bench host model clocks the bus at 5 MHz (200 ns).
// R5: the strap pin gives the address bit on the two-wire bus and read data in 4-wire SPI.
// R6: the data pin carries two-wire data or SPI input, and both directions in 3-wire SPI.
// R7: the host drives the serial clock pin for either protocol.
// R8: protocol select high or floating means two-wire bus, low is the SPI chip select.
// R9: the bus is accepted no later than 250 us after power-up and the host waits that long; the bench host addresses the device straight after reset.
// R10: after entering active mode conversions start after the 1 ms wake-up delay.
// R11: conversions never start before 2 ms after power-up.
// R12: output sample rate is selectable from 1.25 to 1000 samples per second.
// R13: data-ready and motion events drive two mappable interrupt pins.
// R14: a mode sequencer decides which internal blocks run in each mode.
// R15: the mode bit at 0x11 switches standby and active, standby after power-on.
// R16: writing 0xB6 to 0x36 restores all defaults and enters standby from any mode.
module ahp_host_port #(
  parameter int unsigned POR_CYC = ahp_pkg::POR_CYCLES,
  parameter int unsigned WAKE_CYC = ahp_pkg::WAKE_CYCLES,
  parameter int unsigned STARTUP_CYC = ahp_pkg::STARTUP_CYCLES,
  parameter int unsigned MS_CYC = ahp_pkg::MS_CYCLES,
  parameter logic [7:0] CHIP_ID = 8'h5A // arbitrary value
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  input wire logic address_strap_pin_in,
  output logic address_strap_pin_out,
  output logic address_strap_pin_oe_out,
  input wire logic protocol_select_pin_in,
  input wire logic motion_event_in,
  output logic interrupt_out_one_out,
  output logic interrupt_out_two_out,
  output logic conv_start_out,
  output logic mode_active_out
);
  import ahp_pkg::*;

  if (POR_CYC < 2 || WAKE_CYC < 2 || STARTUP_CYC < 2 || MS_CYC < 2 ||
      POR_CYC > 1048576 || WAKE_CYC > 1048576 ||
      STARTUP_CYC > 1048576 || MS_CYC > 1048576)
  begin : g_check
    $error("cycle count parameter out of range");
  end

  // ***************************************************************
  // pin synchronisers: {select, strap, data, clock}
  // ***************************************************************
  logic [3:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_reg <= 4'hF;
      pin_sync_reg <= 4'hF;
      pin_prev_reg <= 4'hF;
    end
    else
    begin
      pin_meta_reg <= {protocol_select_pin_in, address_strap_pin_in,
                       serial_data_pin_in, serial_clock_pin_in};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic scl, sda, strap_pin, chip_select_low;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, cs_fall;
  assign scl = pin_sync_reg[0];
  assign sda = pin_sync_reg[1];
  assign strap_pin = pin_sync_reg[2];
  assign chip_select_low = ~pin_sync_reg[3];
  // plain oversampling, so any rate up to fast mode is served [R4]
  assign scl_rise = scl & ~pin_prev_reg[0];
  assign scl_fall = ~scl & pin_prev_reg[0];
  // start/stop only seen while the select pin is high [R8]
  assign i2c_start = ~chip_select_low & scl & pin_prev_reg[0]
                   & ~sda & pin_prev_reg[1];
  assign i2c_stop = ~chip_select_low & scl & pin_prev_reg[0]
                  & sda & ~pin_prev_reg[1];
  assign cs_fall = chip_select_low & pin_prev_reg[3];

  // ***************************************************************
  // state
  // ***************************************************************
  ahp_mode_t mode_reg, mode_next;
  ahp_ser_t ser_reg, ser_next, ack_to_reg, ack_to_next;
  logic [19:0] mode_cnt_reg, mode_cnt_next, start_cnt_reg, start_cnt_next;
  logic [19:0] ms_cnt_reg, ms_cnt_next;
  logic [9:0] tick_reg, tick_next;
  logic [6:0] drdy_cnt_reg, drdy_cnt_next;
  logic started_reg, started_next, conv_reg, conv_next;
  logic strap_reg, strap_next;
  logic [7:0] shift_reg, shift_next, tx_reg, tx_next, ptr_reg, ptr_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic is_spi_reg, is_spi_next, ack_on_reg, ack_on_next;
  logic drive_reg, drive_next, bit_reg, bit_next;
  logic mode_bit_reg, mode_bit_next, spi3w_reg, spi3w_next;
  logic [3:0] odr_reg, odr_next;
  logic [1:0] map1_reg, map1_next, map2_reg, map2_next;
  logic motion_reg, motion_next, newdata_reg, newdata_next;
  logic interrupt_out_one_reg, interrupt_out_one_next, interrupt_out_two_reg, interrupt_out_two_next;
  logic soft_rst, load, load_drive, byte_done, bus_ready, drdy_pulse;
  logic [7:0] byte_in, load_addr, rd_val;

  assign bus_ready = (mode_reg != MODE_POR); // [R9]
  assign byte_in = {shift_reg[6:0], sda};
  assign byte_done = scl_rise && (bit_cnt_reg == 3'h7);
  assign drdy_pulse = (drdy_cnt_reg != 7'h00);

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    unique case (a)
      REG_CHIP_ID: read_reg = CHIP_ID;
      REG_STATUS: read_reg = {6'h00, motion_reg, newdata_reg};
      REG_ODR: read_reg = {4'h0, odr_reg};
      REG_MODE: read_reg = {mode_bit_reg, 7'h00};
      REG_INTERRUPT_OUT_ONE_MAP: read_reg = {6'h00, map1_reg};
      REG_INTERRUPT_OUT_TWO_MAP: read_reg = {6'h00, map2_reg};
      REG_IFCFG: read_reg = {7'h00, spi3w_reg};
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ***************************************************************
  // serial front end and register file
  // ***************************************************************
  always_comb
  begin
    ser_next = ser_reg;
    ack_to_next = ack_to_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    bit_cnt_next = bit_cnt_reg;
    is_spi_next = is_spi_reg;
    ack_on_next = ack_on_reg;
    drive_next = drive_reg;
    bit_next = bit_reg;
    mode_bit_next = mode_bit_reg;
    spi3w_next = spi3w_reg;
    odr_next = odr_reg;
    map1_next = map1_reg;
    map2_next = map2_reg;
    soft_rst = 1'b0;
    load = 1'b0;
    load_drive = 1'b0;
    load_addr = ptr_reg;
    if (!bus_ready)
    begin
      ser_next = SER_IDLE; // [R9]
      drive_next = 1'b0;
    end
    else if ((is_spi_reg && !chip_select_low) || (!is_spi_reg && i2c_stop))
    begin
      ser_next = SER_IDLE;
      drive_next = 1'b0;
      is_spi_next = 1'b0; // [R8]
    end
    else if (cs_fall || i2c_start)
    begin
      ser_next = SER_DEVADDR; // [R8]
      is_spi_next = cs_fall;
      bit_cnt_next = 3'h0;
      drive_next = 1'b0;
    end
    else
    begin
      if (scl_rise && (ser_reg == SER_DEVADDR || ser_reg == SER_PTR ||
          ser_reg == SER_WRITE))
      begin
        shift_next = byte_in; // [R7]
        bit_cnt_next = bit_cnt_reg + 3'h1;
      end
      unique case (ser_reg)
        SER_IDLE: ;
        SER_DEVADDR:
          if (byte_done && is_spi_reg)
          begin
            ptr_next = {1'b0, byte_in[6:0]};
            if (byte_in[SPI_RW_BIT])
            begin
              ser_next = SER_READ;
              load = 1'b1;
              load_addr = {1'b0, byte_in[6:0]};
            end
            else
              ser_next = SER_WRITE;
          end
          else if (byte_done && byte_in[7:1] == {ADDR_PREFIX, strap_reg})
          begin
            ser_next = SER_ACK; // [R2] [R3]
            ack_to_next = byte_in[0] ? SER_READ : SER_PTR;
            ack_on_next = 1'b0;
          end
          else if (byte_done)
            ser_next = SER_IDLE; // [R2]
        SER_ACK:
          if (scl_fall && !ack_on_reg)
          begin
            ack_on_next = 1'b1;
            drive_next = 1'b1;
            bit_next = 1'b0;
          end
          else if (scl_fall)
          begin
            ser_next = ack_to_reg;
            bit_cnt_next = 3'h0;
            drive_next = 1'b0;
            if (ack_to_reg == SER_READ)
            begin
              load = 1'b1;
              load_drive = 1'b1;
            end
          end
        SER_PTR:
          if (byte_done)
          begin
            ptr_next = byte_in;
            ser_next = SER_ACK;
            ack_to_next = SER_WRITE;
            ack_on_next = 1'b0;
          end
        SER_WRITE:
          if (byte_done)
          begin
            ptr_next = ptr_reg + 8'h01;
            if (!is_spi_reg)
            begin
              ser_next = SER_ACK;
              ack_on_next = 1'b0;
            end
            unique case (ptr_reg)
              REG_ODR: odr_next = byte_in[3:0]; // [R12]
              REG_MODE: mode_bit_next = byte_in[MODE_BIT]; // [R15]
              REG_INTERRUPT_OUT_ONE_MAP: map1_next = byte_in[1:0];
              REG_INTERRUPT_OUT_TWO_MAP: map2_next = byte_in[1:0];
              REG_IFCFG: spi3w_next = byte_in[SPI3W_BIT];
              REG_RESET: soft_rst = (byte_in == SOFT_RESET_CODE); // [R16]
              default: ;
            endcase
          end
        SER_READ:
          if (scl_fall)
          begin
            bit_next = tx_reg[7];
            // open drain on the two-wire bus, push-pull in SPI [R5] [R6]
            drive_next = is_spi_reg | ~tx_reg[7];
          end
          else if (scl_rise)
          begin
            bit_cnt_next = bit_cnt_reg + 3'h1;
            tx_next = {tx_reg[6:0], 1'b0};
            if (bit_cnt_reg == 3'h7 && is_spi_reg)
              load = 1'b1;
            else if (bit_cnt_reg == 3'h7)
              ser_next = SER_RDACK;
          end
        SER_RDACK:
          if (scl_fall)
            drive_next = 1'b0;
          else if (scl_rise && !sda)
          begin
            ser_next = SER_READ;
            bit_cnt_next = 3'h0;
            load = 1'b1;
          end
          else if (scl_rise)
            ser_next = SER_IDLE;
        default: ser_next = SER_IDLE;
      endcase
    end
    rd_val = read_reg(load_addr);
    if (load)
    begin
      tx_next = rd_val;
      ptr_next = load_addr + 8'h01; // auto-increment for bursts
    end
    if (load_drive)
    begin
      bit_next = rd_val[7];
      drive_next = ~rd_val[7];
    end
    if (soft_rst)
    begin
      mode_bit_next = 1'b0; // [R16]
      spi3w_next = 1'b0;
      odr_next = ODR_DEFAULT;
      map1_next = MAP_DEFAULT;
      map2_next = MAP_DEFAULT;
    end
    // a new event wins over a status read in the same cycle
    newdata_next = conv_reg | (newdata_reg
                 & ~(load && load_addr == REG_STATUS));
    motion_next = (motion_event_in && mode_reg == MODE_ACTIVE)
                | (motion_reg & ~(load && load_addr == REG_STATUS));
    if (soft_rst)
    begin
      newdata_next = 1'b0;
      motion_next = 1'b0;
    end
    interrupt_out_one_next = |(map1_reg & {motion_reg, drdy_pulse}); // [R13]
    interrupt_out_two_next = |(map2_reg & {motion_reg, drdy_pulse}); // [R13]
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ser_reg <= SER_IDLE; // [R1]
      ack_to_reg <= SER_PTR;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      is_spi_reg <= 1'b0;
      ack_on_reg <= 1'b0;
      drive_reg <= 1'b0;
      bit_reg <= 1'b0;
      mode_bit_reg <= 1'b0; // [R15]
      spi3w_reg <= 1'b0;
      odr_reg <= ODR_DEFAULT;
      map1_reg <= MAP_DEFAULT;
      map2_reg <= MAP_DEFAULT;
      newdata_reg <= 1'b0;
      motion_reg <= 1'b0;
      interrupt_out_one_reg <= 1'b0;
      interrupt_out_two_reg <= 1'b0;
    end
    else
    begin
      ser_reg <= ser_next;
      ack_to_reg <= ack_to_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      bit_cnt_reg <= bit_cnt_next;
      is_spi_reg <= is_spi_next;
      ack_on_reg <= ack_on_next;
      drive_reg <= drive_next;
      bit_reg <= bit_next;
      mode_bit_reg <= mode_bit_next;
      spi3w_reg <= spi3w_next;
      odr_reg <= odr_next;
      map1_reg <= map1_next;
      map2_reg <= map2_next;
      newdata_reg <= newdata_next;
      motion_reg <= motion_next;
      interrupt_out_one_reg <= interrupt_out_one_next;
      interrupt_out_two_reg <= interrupt_out_two_next;
    end
  end

  // ***************************************************************
  // mode sequencer and sample timer
  // ***************************************************************
  always_comb
  begin
    mode_next = mode_reg;
    mode_cnt_next = mode_cnt_reg;
    ms_cnt_next = ms_cnt_reg;
    tick_next = tick_reg;
    conv_next = 1'b0;
    strap_next = strap_reg;
    started_next = started_reg;
    start_cnt_next = start_cnt_reg;
    if (!started_reg)
    begin
      start_cnt_next = start_cnt_reg + 20'h00001;
      started_next = (start_cnt_reg == 20'(STARTUP_CYC - 1)); // [R11]
    end
    unique case (mode_reg)
      MODE_POR:
      begin
        mode_cnt_next = mode_cnt_reg + 20'h00001;
        if (mode_cnt_reg == 20'(POR_CYC - 1))
        begin
          mode_next = MODE_STANDBY; // [R1]
          mode_cnt_next = 20'h00000;
          strap_next = strap_pin; // [R3] [R5]
        end
      end
      MODE_STANDBY:
        if (mode_bit_reg)
        begin
          mode_next = MODE_WAKE; // [R15]
          mode_cnt_next = 20'h00000;
        end
      MODE_WAKE:
        if (!mode_bit_reg)
          mode_next = MODE_STANDBY;
        else if (mode_cnt_reg != 20'(WAKE_CYC - 1))
          mode_cnt_next = mode_cnt_reg + 20'h00001;
        else if (started_reg)
        begin
          mode_next = MODE_ACTIVE; // [R10] [R11]
          ms_cnt_next = 20'h00000;
          tick_next = 10'h000;
        end
      MODE_ACTIVE:
        if (!mode_bit_reg)
          mode_next = MODE_STANDBY; // [R14]
        else if (ms_cnt_reg != 20'(MS_CYC - 1))
          ms_cnt_next = ms_cnt_reg + 20'h00001;
        else
        begin
          ms_cnt_next = 20'h00000;
          tick_next = tick_reg + 10'h001;
          if (tick_reg >= odr_ticks(odr_reg) - 10'h001)
          begin
            tick_next = 10'h000;
            conv_next = 1'b1; // [R12]
          end
        end
    endcase
    if (soft_rst)
    begin
      mode_next = MODE_STANDBY; // [R16]
      mode_cnt_next = 20'h00000;
    end
    // data-ready pin pulse is non-latched
    if (conv_reg)
      drdy_cnt_next = DRDY_PULSE_CYCLES;
    else if (drdy_pulse)
      drdy_cnt_next = drdy_cnt_reg - 7'h01;
    else
      drdy_cnt_next = 7'h00;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_reg <= MODE_POR;
      mode_cnt_reg <= 20'h00000;
      ms_cnt_reg <= 20'h00000;
      tick_reg <= 10'h000;
      conv_reg <= 1'b0;
      strap_reg <= 1'b0;
      started_reg <= 1'b0;
      start_cnt_reg <= 20'h00000;
      drdy_cnt_reg <= 7'h00;
    end
    else
    begin
      mode_reg <= mode_next;
      mode_cnt_reg <= mode_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
      tick_reg <= tick_next;
      conv_reg <= conv_next;
      strap_reg <= strap_next;
      started_reg <= started_next;
      start_cnt_reg <= start_cnt_next;
      drdy_cnt_reg <= drdy_cnt_next;
    end
  end

  assign serial_data_pin_out = is_spi_reg & bit_reg;
  assign serial_data_pin_oe_out = drive_reg & (~is_spi_reg | spi3w_reg);
  assign address_strap_pin_out = bit_reg;
  assign address_strap_pin_oe_out = drive_reg & is_spi_reg & ~spi3w_reg;
  assign interrupt_out_one_out = interrupt_out_one_reg;
  assign interrupt_out_two_out = interrupt_out_two_reg;
  assign conv_start_out = conv_reg;
  assign mode_active_out = (mode_reg == MODE_ACTIVE); // [R14]

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [7:0] hi_len_reg;
  always_ff @(posedge clk_in)
    hi_len_reg <= (sys_rst_in || !drdy_pulse) ? 8'h00 : hi_len_reg + 8'h01;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_por_quiet;
    (mode_reg == MODE_POR) |-> !drive_reg && ser_reg == SER_IDLE;
  endproperty
  a_por_quiet: assert property (p_por_quiet) // [R9]
    else $error("bus answered before reset finished");
  property p_standby_after_por;
    (mode_reg == MODE_POR && mode_cnt_reg == 20'(POR_CYC - 1))
      |=> mode_reg == MODE_STANDBY && !mode_bit_reg;
  endproperty
  a_standby_after_por: assert property (p_standby_after_por) // [R1]
    else $error("no standby after power-on reset");
  property p_soft_reset;
    soft_rst |=> mode_reg == MODE_STANDBY && !mode_bit_reg
      && odr_reg == ODR_DEFAULT;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R16]
    else $error("soft reset did not restore defaults");
  property p_addr_ack;
    (ser_reg == SER_DEVADDR && byte_done && !is_spi_reg && !i2c_stop
      && !i2c_start && byte_in[7:1] == {ADDR_PREFIX, strap_reg})
      |=> ser_reg == SER_ACK ##[1:1000] drive_reg;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // [R2]
    else $error("own address not acknowledged");
  property p_foreign_addr;
    (ser_reg == SER_DEVADDR && byte_done && !is_spi_reg && !i2c_stop
      && !i2c_start && byte_in[7:1] != {ADDR_PREFIX, strap_reg})
      |=> ser_reg == SER_IDLE;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) // [R3]
    else $error("foreign address accepted");
  property p_spi4_pin;
    (drive_reg && is_spi_reg && !spi3w_reg)
      |-> address_strap_pin_oe_out && !serial_data_pin_oe_out;
  endproperty
  a_spi4_pin: assert property (p_spi4_pin) // [R5]
    else $error("4-wire read data not on strap pin");
  property p_spi3_pin;
    (drive_reg && is_spi_reg && spi3w_reg)
      |-> serial_data_pin_oe_out && !address_strap_pin_oe_out;
  endproperty
  a_spi3_pin: assert property (p_spi3_pin) // [R6]
    else $error("3-wire read data not on data pin");
  property p_wake_time;
    $rose(mode_reg == MODE_ACTIVE)
      |-> $past(mode_cnt_reg) == 20'(WAKE_CYC - 1) && started_reg;
  endproperty
  a_wake_time: assert property (p_wake_time) // [R10]
    else $error("active mode entered before wake-up delay");
  property p_conv_active;
    conv_next |-> mode_reg == MODE_ACTIVE && started_reg;
  endproperty
  a_conv_active: assert property (p_conv_active) // [R11]
    else $error("conversion outside active mode");
  property p_drdy_width;
    $fell(drdy_pulse) |-> hi_len_reg == 8'h40;
  endproperty
  a_drdy_width: assert property (p_drdy_width) // [R13]
    else $error("data-ready pulse width wrong");
  property p_mode_bit;
    (mode_reg == MODE_ACTIVE && !mode_bit_reg) |=> mode_reg == MODE_STANDBY;
  endproperty
  a_mode_bit: assert property (p_mode_bit) // [R15]
    else $error("mode bit clear did not enter standby");

  c_i2c_read: cover property (ser_reg == SER_RDACK ##[1:400]
    ser_reg == SER_READ);
  c_spi_write: cover property (is_spi_reg && byte_done && ser_reg == SER_WRITE);
  c_active: cover property ($rose(mode_reg == MODE_ACTIVE));
  c_interrupt_out_one: cover property ($rose(interrupt_out_one_out));

endmodule

// >>> verif/ahp_host_model.sv
`timescale 1ns/10ps
module ahp_host_model (
  input wire logic clk_in,
  input wire logic data_in,
  input wire logic miso_in,
  output logic clock_out,
  output logic data_oe_out,
  output logic data_val_out,
  output logic select_n_out
);
  // ****
  // bus master, 200 ns link clock, idle high outside frames
  // ****
  initial
  begin
    clock_out = 1'b1;
    data_oe_out = 1'b0;
    data_val_out = 1'b0;
    select_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // two-wire only pulls low; spi drives both levels
  task automatic pulse(input logic b, output logic s);
    clock_out = 1'b0;
    tick(1);
    data_val_out = b;
    data_oe_out = ~select_n_out | ~b;
    tick(3);
    clock_out = 1'b1;
    tick(2);
    s = select_n_out ? data_in : miso_in;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      pulse(w[i], r[i]);
  endtask
  task automatic i2c_byte(input logic [7:0] w, output logic ack);
    logic [7:0] r;
    logic s;
    xfer(w, r);
    pulse(1'b1, s);
    ack = ~s;
  endtask
  task automatic start();
    data_oe_out = 1'b1;
    data_val_out = 1'b0;
    tick(4);
  endtask
  // clock low first so the slave lets go of its ack
  task automatic restart();
    clock_out = 1'b0;
    tick(4);
    clock_out = 1'b1;
    tick(4);
    start();
  endtask
  task automatic stop();
    clock_out = 1'b0;
    tick(1);
    data_oe_out = 1'b1;
    tick(3);
    clock_out = 1'b1;
    tick(4);
    data_oe_out = 1'b0;
    tick(4);
  endtask
  task automatic spi(input logic [7:0] c, input logic [7:0] w,
    output logic [7:0] r);
    select_n_out = 1'b0;
    tick(4);
    xfer(c, r);
    xfer(w, r);
    select_n_out = 1'b1;
    data_oe_out = 1'b0;
    tick(4);
  endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ****
  // bench: host model on the pins, strap level from the bench
  // ****
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic strap = 1'b0;
  logic motion = 1'b0;
  logic spi3_on = 1'b0;
  logic d_out, d_oe, a_out, a_oe, scl, m_oe, m_val, sel_n;
  logic irq1, irq2, conv, act;
  logic [2:0] ack;
  logic [7:0] r, r2;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  // pull-up on the data line, wired-and of both drivers
  wire logic sda = (d_oe ? d_out : 1'b1) & (m_oe ? m_val : 1'b1);
  wire logic ad = a_oe ? a_out : strap;
  ahp_host_port #(.POR_CYC(20), .WAKE_CYC(40), .STARTUP_CYC(80),
    .MS_CYC(10)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .serial_clock_pin_in(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(d_out), .serial_data_pin_oe_out(d_oe),
    .address_strap_pin_in(ad), .address_strap_pin_out(a_out),
    .address_strap_pin_oe_out(a_oe), .protocol_select_pin_in(sel_n),
    .motion_event_in(motion), .interrupt_out_one_out(irq1),
    .interrupt_out_two_out(irq2), .conv_start_out(conv),
    .mode_active_out(act));
  // 3-wire reads come back on the data pin
  ahp_host_model host_u (.clk_in(clk_in), .data_in(sda),
    .miso_in(spi3_on ? sda : ad),
    .clock_out(scl), .data_oe_out(m_oe), .data_val_out(m_val),
    .select_n_out(sel_n));
  initial
    forever #12.5 clk_in = ~clk_in;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // sized well above the whole sequence, about 3000 cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic do_reset(input logic s);
    strap = s;
    sys_rst_in = 1'b1;
    host_u.tick(20);
    sys_rst_in = 1'b0;
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr,
    input logic [7:0] val);
    host_u.start();
    host_u.i2c_byte(dev, ack[2]);
    host_u.i2c_byte(ptr, ack[1]);
    host_u.i2c_byte(val, ack[0]);
    host_u.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] v1,
    output logic [7:0] v2);
    logic s;
    host_u.start();
    host_u.i2c_byte(8'h24, ack[2]);
    host_u.i2c_byte(ptr, ack[1]);
    host_u.restart();
    host_u.i2c_byte(8'h25, ack[0]);
    host_u.xfer(8'hFF, v1);
    host_u.pulse(1'b0, s);
    host_u.xfer(8'hFF, v2);
    host_u.pulse(1'b1, s);
    host_u.stop();
  endtask
  task automatic t_por_and_address();
    wr(8'h24, 8'h11, 8'h80);
    check(ack, 8'h00);
    check(act, 8'h00);
    wr(8'h24, 8'h19, 8'h02);
    check(ack, 8'h07);
    wr(8'h26, 8'h19, 8'h02);
    check(ack, 8'h00);
  endtask
  task automatic t_active();
    int n;
    n = 0;
    wr(8'h24, 8'h11, 8'h80);
    check(act, 8'h00);
    repeat (30) @(negedge clk_in) n += conv;
    check(n[7:0], 8'h00);
    check(act, 8'h01);
    n = 0;
    while (conv !== 1'b1 && n < 300) @(negedge clk_in) n++;
    check(conv, 8'h01);
    motion = 1'b1;
    host_u.tick(1);
    motion = 1'b0;
    host_u.tick(3);
    check(irq1, 8'h01);
    check(irq2, 8'h00);
    rd(8'h10, r, r2);
    check(ack, 8'h07);
    check(r, 8'h04);
    check(r2, 8'h80);
  endtask
  task automatic t_soft_reset();
    wr(8'h24, 8'h36, 8'hB6);
    host_u.tick(3);
    check(act, 8'h00);
    check(irq1, 8'h00);
  endtask
  task automatic t_spi();
    host_u.spi(8'h11, 8'h80, r);
    host_u.tick(40);
    check(act, 8'h01);
    host_u.spi(8'h91, 8'h00, r);
    check(r, 8'h80);
    check(a_oe, 8'h00);
  endtask
  task automatic t_spi3();
    host_u.spi(8'h20, 8'h01, r);
    spi3_on = 1'b1;
    host_u.spi(8'h91, 8'hFF, r);
    check(r, 8'h80);
    check(d_oe, 8'h00);
    spi3_on = 1'b0;
    wr(8'h24, 8'h11, 8'h00);
    check(ack, 8'h07);
    check(act, 8'h00);
  endtask
  task automatic t_strap_high();
    do_reset(1'b1);
    host_u.tick(30);
    wr(8'h26, 8'h11, 8'h00);
    check(ack, 8'h07);
    wr(8'h24, 8'h11, 8'h00);
    check(ack, 8'h00);
  endtask
  initial
  begin
    do_reset(1'b0);
    t_por_and_address();
    t_active();
    t_soft_reset();
    t_spi();
    t_spi3();
    t_strap_high();
    conclude();
  end
endmodule
